// ### design/supply_monitor_pkg.sv
package supply_monitor_pkg;
    // --------------------------------------------------------------
    // register indices (word index, byte address is four times)
    // --------------------------------------------------------------
    localparam logic [3:0] ADDR_LVD_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_IRQ_REQUEST = 4'h1;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
    localparam logic [3:0] ADDR_IRQ_CONFIG = 4'h3;
    localparam logic [3:0] ADDR_IRQ_SET = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASKED = 4'h5;
    localparam logic [3:0] ADDR_MODE = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int THRESH_LSB = 0;
    localparam int THRESH_W = 4;
    localparam int SOURCE_LSB = 4;
    localparam int SOURCE_W = 3;
    localparam int ENABLE_BIT = 7;
    localparam int PENDING_BIT = 1;
    localparam int EDGE_LSB = 0;
    localparam int EDGE_W = 2;
    localparam int MODE_W = 3;

    // --------------------------------------------------------------
    // reset values and encodings
    // --------------------------------------------------------------
    localparam logic [7:0] LVD_CONFIG_RST = 8'h00;
    localparam logic [1:0] EDGE_DISABLED = 2'h0;
    localparam logic [1:0] EDGE_RISING = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'h0,
        MODE_LP_ACTIVE = 3'h1,
        MODE_SLEEP = 3'h2,
        MODE_LP_SLEEP = 3'h3,
        MODE_DEEP_SLEEP = 3'h4,
        MODE_HIBERNATE = 3'h5
    } power_mode_t;

    typedef enum logic [1:0] {
        ST_POWER_UP = 2'b00,
        ST_RUN = 2'b01,
        ST_BROWNOUT = 2'b11
    } seq_state_t;
endpackage

// ### design/supply_monitor_reset_lvd_irq.sv
// Operation
// - hold reset until digital and analog valid
// - power-on pulse only during first ramp
// - brownout on main or core supply resets
// - brownout reset holds while supply invalid
// - brownout ignored in hibernate
// - overvoltage resets except in hibernate
// - source field selects monitored supply
// - threshold field selects trip level
// - enable bit gates low-voltage detector
// - crossing below threshold sets pending
// - mask gates pending onto cpu irq
// - masked register is request and mask
// - set register forces request bits
// - edge field picks irq edge
// - write one clears, live condition stays
// - detector only in active, lp active, sleep and lp sleep modes
module supply_monitor_reset_lvd_irq #(
    parameter int ADDR_W = 4
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic digital_ok_in,
    input wire logic analog_ok_in,
    input wire logic power_on_det_in,
    input wire logic main_supply_brownout_in,
    input wire logic core_supply_brownout_in,
    input wire logic overvoltage_guard_in,
    input wire logic lowvolt_below_in,
    output logic system_reset_out,
    output logic power_on_det_en_out,
    output logic lowvolt_enable_out,
    output logic [2:0] lowvolt_source_sel_out,
    output logic [3:0] lowvolt_threshold_sel_out,
    output logic cpu_irq_out
);
    if (ADDR_W < 3) begin : g_addr_check
        $error("addr width too small");
    end

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [7:0] lvd_config;
    logic [7:0] next_lvd_config;
    logic [1:0] irq_config;
    logic [1:0] next_irq_config;
    logic irq_mask;
    logic next_irq_mask;
    logic lowvolt_pending;
    logic next_lowvolt_pending;
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic sync1, sync2, sync_prev;
    logic [31:0] next_rdata;
    logic next_irq;
    supply_monitor_pkg::seq_state_t state, next_state;
    logic next_reset;
    logic next_por_en;

    wire hib = mode == 3'(supply_monitor_pkg::MODE_HIBERNATE);
    wire lvd_mode_ok = mode <= 3'(supply_monitor_pkg::MODE_LP_SLEEP);
    wire brownout = !hib &&
        (main_supply_brownout_in || core_supply_brownout_in);
    wire overvolt = !hib && overvoltage_guard_in;
    wire supplies_ok = digital_ok_in && analog_ok_in;
    wire en = lvd_config[supply_monitor_pkg::ENABLE_BIT];
    wire live = en && lvd_mode_ok && sync2;
    wire fall_ev = live && !sync_prev;
    wire rise_ev = en && lvd_mode_ok && !sync2 && sync_prev;
    wire sel_fall = irq_config == supply_monitor_pkg::EDGE_FALLING ||
        irq_config == supply_monitor_pkg::EDGE_BOTH;
    wire sel_rise = irq_config == supply_monitor_pkg::EDGE_RISING ||
        irq_config == supply_monitor_pkg::EDGE_BOTH;
    wire lv_event = (fall_ev && sel_fall) || (rise_ev && sel_rise);
    wire sel_req = addr_in == ADDR_W'(supply_monitor_pkg::ADDR_IRQ_REQUEST);
    wire sel_set = addr_in == ADDR_W'(supply_monitor_pkg::ADDR_IRQ_SET);
    wire wbit = wdata_in[supply_monitor_pkg::PENDING_BIT];

    // --------------------------------------------------------------
    // comparator synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync1 <= lowvolt_below_in;
            sync2 <= sync1;
            sync_prev <= sync2;
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_comb begin
        next_lvd_config = lvd_config;
        next_irq_config = irq_config;
        next_irq_mask = irq_mask;
        next_mode = mode;
        next_lowvolt_pending = lowvolt_pending;
        if (wr_in && sel_req && wbit && !live) begin
            next_lowvolt_pending = 1'b0;
        end
        if (wr_in && sel_set && wbit) begin
            next_lowvolt_pending = 1'b1;
        end
        if (lv_event) begin
            next_lowvolt_pending = 1'b1;
        end
        if (wr_in) begin
            case (addr_in)
                ADDR_W'(supply_monitor_pkg::ADDR_LVD_CONFIG): begin
                    next_lvd_config = wdata_in[7:0];
                end
                ADDR_W'(supply_monitor_pkg::ADDR_IRQ_MASK): begin
                    next_irq_mask = wbit;
                end
                ADDR_W'(supply_monitor_pkg::ADDR_IRQ_CONFIG): begin
                    next_irq_config = wdata_in[1:0];
                end
                ADDR_W'(supply_monitor_pkg::ADDR_MODE): begin
                    next_mode = wdata_in[2:0];
                end
                default: begin
                    next_mode = mode;
                end
            endcase
        end
        next_irq = next_lowvolt_pending && next_irq_mask;
        next_rdata = 32'h0;
        if (rd_in) begin
            case (addr_in)
                ADDR_W'(supply_monitor_pkg::ADDR_LVD_CONFIG): begin
                    next_rdata[7:0] = lvd_config;
                end
                ADDR_W'(supply_monitor_pkg::ADDR_IRQ_REQUEST): begin
                    next_rdata[supply_monitor_pkg::PENDING_BIT] =
                        lowvolt_pending;
                end
                ADDR_W'(supply_monitor_pkg::ADDR_IRQ_MASK): begin
                    next_rdata[supply_monitor_pkg::PENDING_BIT] = irq_mask;
                end
                ADDR_W'(supply_monitor_pkg::ADDR_IRQ_CONFIG): begin
                    next_rdata[1:0] = irq_config;
                end
                ADDR_W'(supply_monitor_pkg::ADDR_IRQ_MASKED): begin
                    next_rdata[supply_monitor_pkg::PENDING_BIT] =
                        lowvolt_pending && irq_mask;
                end
                ADDR_W'(supply_monitor_pkg::ADDR_MODE): begin
                    next_rdata[2:0] = mode;
                end
                ADDR_W'(supply_monitor_pkg::ADDR_STATUS): begin
                    next_rdata[3:0] = {sync2, supplies_ok, state};
                end
                default: begin
                    next_rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            lvd_config <= supply_monitor_pkg::LVD_CONFIG_RST;
            irq_config <= supply_monitor_pkg::EDGE_DISABLED;
            irq_mask <= 1'b0;
            lowvolt_pending <= 1'b0;
            mode <= 3'(supply_monitor_pkg::MODE_ACTIVE);
            rdata_out <= 32'h0;
            cpu_irq_out <= 1'b0;
        end else begin
            lvd_config <= next_lvd_config;
            irq_config <= next_irq_config;
            irq_mask <= next_irq_mask;
            lowvolt_pending <= next_lowvolt_pending;
            mode <= next_mode;
            rdata_out <= next_rdata;
            cpu_irq_out <= next_irq;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            lowvolt_enable_out <= 1'b0;
            lowvolt_source_sel_out <= 3'h0;
            lowvolt_threshold_sel_out <= 4'h0;
        end else begin
            lowvolt_enable_out <= next_lvd_config[7];
            lowvolt_source_sel_out <= next_lvd_config[6:4];
            lowvolt_threshold_sel_out <= next_lvd_config[3:0];
        end
    end

    // --------------------------------------------------------------
    // reset sequencer
    // --------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_reset = 1'b1;
        next_por_en = 1'b0;
        case (state)
            supply_monitor_pkg::ST_POWER_UP: begin
                next_por_en = 1'b1;
                if (supplies_ok && !power_on_det_in && !brownout &&
                    !overvolt) begin
                    next_state = supply_monitor_pkg::ST_RUN;
                    next_reset = 1'b0;
                    next_por_en = 1'b0;
                end
            end
            supply_monitor_pkg::ST_RUN: begin
                next_reset = 1'b0; // detector ignored here
                if (brownout || overvolt || !supplies_ok) begin
                    next_state = supply_monitor_pkg::ST_BROWNOUT;
                    next_reset = 1'b1;
                end
            end
            supply_monitor_pkg::ST_BROWNOUT: begin
                if (!brownout && !overvolt && supplies_ok) begin
                    next_state = supply_monitor_pkg::ST_RUN;
                    next_reset = 1'b0;
                end
            end
            default: begin
                next_state = supply_monitor_pkg::ST_POWER_UP;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state <= supply_monitor_pkg::ST_POWER_UP;
            system_reset_out <= 1'b1;
            power_on_det_en_out <= 1'b1;
        end else begin
            state <= next_state;
            system_reset_out <= next_reset;
            power_on_det_en_out <= next_por_en;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_hold_until_ok;
        @(posedge ref_clk_in) disable iff (rst_in)
        !supplies_ok |=> system_reset_out;
    endproperty
    a_hold_until_ok: assert property (p_hold_until_ok)
        else $error("reset released without supplies");

    property p_por_off;
        @(posedge ref_clk_in) disable iff (rst_in)
        (state == supply_monitor_pkg::ST_RUN) |=> !power_on_det_en_out;
    endproperty
    a_por_off: assert property (p_por_off)
        else $error("power-on detector left enabled");

    property p_brownout;
        @(posedge ref_clk_in) disable iff (rst_in)
        brownout |=> system_reset_out;
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("brownout did not reset");

    property p_brown_hold;
        @(posedge ref_clk_in) disable iff (rst_in)
        system_reset_out && brownout |=> system_reset_out;
    endproperty
    a_brown_hold: assert property (p_brown_hold)
        else $error("reset dropped while supply invalid");

    property p_hib;
        @(posedge ref_clk_in) disable iff (rst_in)
        (state == supply_monitor_pkg::ST_RUN) && hib && supplies_ok
            |=> !system_reset_out;
    endproperty
    a_hib: assert property (p_hib)
        else $error("reset in hibernate");

    property p_ovp;
        @(posedge ref_clk_in) disable iff (rst_in)
        overvoltage_guard_in && !hib |=> system_reset_out;
    endproperty
    a_ovp: assert property (p_ovp)
        else $error("overvoltage did not reset");

    sequence s_fall_seen;
        lv_event;
    endsequence
    property p_pending;
        @(posedge ref_clk_in) disable iff (rst_in)
        s_fall_seen |=> lowvolt_pending;
    endproperty
    a_pending: assert property (p_pending)
        else $error("pending not set on edge");

    property p_irq;
        @(posedge ref_clk_in) disable iff (rst_in)
        cpu_irq_out == (lowvolt_pending && irq_mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq without pending");

    property p_set;
        @(posedge ref_clk_in) disable iff (rst_in)
        wr_in && sel_set && wbit |=> lowvolt_pending;
    endproperty
    a_set: assert property (p_set)
        else $error("set register failed");

    property p_edge_off;
        @(posedge ref_clk_in) disable iff (rst_in)
        irq_config == supply_monitor_pkg::EDGE_DISABLED |-> !lv_event;
    endproperty
    a_edge_off: assert property (p_edge_off)
        else $error("event with edge disabled");

    property p_clear_live;
        @(posedge ref_clk_in) disable iff (rst_in)
        lowvolt_pending && wr_in && sel_req && wbit && live
            |=> lowvolt_pending;
    endproperty
    a_clear_live: assert property (p_clear_live)
        else $error("pending cleared while condition live");

    property p_deep;
        @(posedge ref_clk_in) disable iff (rst_in)
        !lvd_mode_ok |-> !lv_event;
    endproperty
    a_deep: assert property (p_deep)
        else $error("event outside allowed modes");
endmodule // supply_monitor_reset_lvd_irq

// ### sim/lowvolt_comparator_model.sv
module lowvolt_comparator_model (
    input wire logic [15:0] rail_levels_in,
    input wire logic lowvolt_enable_in,
    input wire logic [2:0] lowvolt_source_sel_in,
    input wire logic [3:0] lowvolt_threshold_sel_in,
    output logic lowvolt_below_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] level;
    // ----------------------------------------------------------
    // comparator: selected rail against selected trip level
    // ----------------------------------------------------------
    always_comb begin
        level = rail_levels_in[4*lowvolt_source_sel_in[1:0] +: 4];
        lowvolt_below_out = lowvolt_enable_in
            && (level < lowvolt_threshold_sel_in);
    end
endmodule // lowvolt_comparator_model

// ### sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic dig_ok = 1'b0;
    logic ana_ok = 1'b0;
    logic por = 1'b1;
    logic [2:0] fault = 3'h0;
    logic [15:0] rails = 16'hFFFF;
    logic below, sys_rst, por_en, lv_en, irq;
    logic [2:0] src;
    logic [3:0] thr;
    int fails = 0;
    int samples_checked = 0;

    always #20 ref_clk = ~ref_clk;

    supply_monitor_reset_lvd_irq #(.ADDR_W(4)) supply_monitor_reset_lvd_irq_i (
        .ref_clk_in(ref_clk), .rst_in(rst), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .digital_ok_in(dig_ok), .analog_ok_in(ana_ok),
        .power_on_det_in(por), .main_supply_brownout_in(fault[0]),
        .core_supply_brownout_in(fault[1]),
        .overvoltage_guard_in(fault[2]), .lowvolt_below_in(below),
        .system_reset_out(sys_rst), .power_on_det_en_out(por_en),
        .lowvolt_enable_out(lv_en), .lowvolt_source_sel_out(src),
        .lowvolt_threshold_sel_out(thr), .cpu_irq_out(irq));

    lowvolt_comparator_model lowvolt_comparator_model_i (
        .rail_levels_in(rails), .lowvolt_enable_in(lv_en),
        .lowvolt_source_sel_in(src), .lowvolt_threshold_sel_in(thr),
        .lowvolt_below_out(below));

    // ----------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e,
                          input string what);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(what, e, rdata);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_rst(input logic e);
        int n;
        n = 0;
        while (sys_rst !== e && n < 10) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("system_reset_out", {31'h0, e}, {31'h0, sys_rst});
    endtask

    task automatic report_and_stop;
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        cycles(1);
        chk("power_on_det_en_out", 32'h1, {31'h0, por_en});
        for (int i = 0; i < 6; i++) begin
            rd_reg(4'(i), 32'h0, "register reset value");
        end
        @(posedge ref_clk);
        por <= 1'b0;
        dig_ok <= 1'b1;
        cycles(6);
        chk("system_reset_out", 32'h1, {31'h0, sys_rst});
        @(posedge ref_clk);
        ana_ok <= 1'b1;
        wait_rst(1'b0);
        chk("power_on_det_en_out", 32'h0, {31'h0, por_en});
        @(posedge ref_clk);
        por <= 1'b1;
        cycles(5);
        chk("system_reset_out", 32'h0, {31'h0, sys_rst});
        @(posedge ref_clk);
        por <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            fault <= 3'h1 << k;
            wait_rst(1'b1);
            cycles(6);
            chk("system_reset_out", 32'h1, {31'h0, sys_rst});
            @(posedge ref_clk);
            fault <= 3'h0;
            wait_rst(1'b0);
        end
        wr_reg(supply_monitor_pkg::ADDR_MODE, 32'h5);
        rd_reg(supply_monitor_pkg::ADDR_MODE, 32'h5, "mode");
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            fault <= 3'h1 << k;
            cycles(6);
            chk("system_reset_out", 32'h0, {31'h0, sys_rst});
            @(posedge ref_clk);
            fault <= 3'h0;
        end
        wr_reg(supply_monitor_pkg::ADDR_MODE, 32'h0);
        wr_reg(4'hF, 32'hFFFFFFFF);
        rd_reg(4'hF, 32'h0, "unmapped register");
        rd_reg(supply_monitor_pkg::ADDR_STATUS, 32'h5, "status");
        wr_reg(supply_monitor_pkg::ADDR_LVD_CONFIG, 32'h39);
        wr_reg(supply_monitor_pkg::ADDR_LVD_CONFIG, 32'hB9);
        rd_reg(supply_monitor_pkg::ADDR_LVD_CONFIG, 32'hB9, "lvd_config");
        chk("lowvolt ports", 32'hB9,
            {24'h0, lv_en, src, thr});
        for (int e = 0; e < 4; e++) begin
            wr_reg(supply_monitor_pkg::ADDR_IRQ_CONFIG, 32'(e));
            wr_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h2);
            @(posedge ref_clk);
            rails <= 16'h2FFF;
            cycles(5);
            rd_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, e[1] ? 32'h2 : 32'h0,
                   "pending after drop");
            @(posedge ref_clk);
            rails <= 16'hFFFF;
            cycles(5);
            rd_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST,
                   e != 0 ? 32'h2 : 32'h0,
                   "pending after recovery");
        end
        wr_reg(supply_monitor_pkg::ADDR_LVD_CONFIG, 32'h09);
        wr_reg(supply_monitor_pkg::ADDR_LVD_CONFIG, 32'h89);
        wr_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h2);
        @(posedge ref_clk);
        rails <= 16'h2FFF;
        cycles(5);
        rd_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h0,
               "other source");
        @(posedge ref_clk);
        rails <= 16'hFFFF;
        wr_reg(supply_monitor_pkg::ADDR_IRQ_MASK, 32'h0);
        wr_reg(supply_monitor_pkg::ADDR_LVD_CONFIG, 32'h39);
        wr_reg(supply_monitor_pkg::ADDR_IRQ_CONFIG, 32'h2);
        wr_reg(supply_monitor_pkg::ADDR_LVD_CONFIG, 32'hB9);
        cycles(200);
        wr_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h2);
        wr_reg(supply_monitor_pkg::ADDR_IRQ_MASK, 32'h2);
        @(posedge ref_clk);
        rails <= 16'h2FFF;
        cycles(2);
        chk("cpu_irq_out early", 32'h0, {31'h0, irq});
        cycles(1);
        chk("cpu_irq_out", 32'h1, {31'h0, irq});
        rd_reg(supply_monitor_pkg::ADDR_IRQ_MASKED, 32'h2, "masked");
        wr_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h2);
        rd_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h2,
               "live clear");
        @(posedge ref_clk);
        rails <= 16'hFFFF;
        cycles(4);
        wr_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h2);
        rd_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h0, "clear");
        wr_reg(supply_monitor_pkg::ADDR_IRQ_MASK, 32'h0);
        wr_reg(supply_monitor_pkg::ADDR_IRQ_SET, 32'h2);
        rd_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h2, "set");
        rd_reg(supply_monitor_pkg::ADDR_IRQ_SET, 32'h0, "set readback");
        chk("cpu_irq_out masked", 32'h0, {31'h0, irq});
        rd_reg(supply_monitor_pkg::ADDR_IRQ_MASKED, 32'h0, "masked");
        wr_reg(supply_monitor_pkg::ADDR_IRQ_MASK, 32'h2);
        cycles(2);
        chk("cpu_irq_out unmasked", 32'h1, {31'h0, irq});
        wr_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h2);
        wr_reg(supply_monitor_pkg::ADDR_IRQ_CONFIG, 32'h1);
        wr_reg(supply_monitor_pkg::ADDR_MODE, 32'h4);
        @(posedge ref_clk);
        rails <= 16'h2FFF;
        cycles(5);
        @(posedge ref_clk);
        rails <= 16'hFFFF;
        cycles(5);
        rd_reg(supply_monitor_pkg::ADDR_IRQ_REQUEST, 32'h0,
               "deep sleep");
        wr_reg(supply_monitor_pkg::ADDR_MODE, 32'h0);
        wr_reg(supply_monitor_pkg::ADDR_IRQ_CONFIG, 32'h2);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end
endmodule // testbench
